// ### hdl/ccei_defines.vh
// Constants for the comparator control, edge flag and interrupt block.
// Assumes inclusion by bare name from the design file.
`ifndef CCEI_DEFINES_VH
`define CCEI_DEFINES_VH
// ==========================================================
// Register addresses and pages
`define CCEI_CTRL_ADDR     8'h88
`define CCEI_MODE_ADDR     8'h89
`define CCEI_PAGE_CMP0     8'h01
`define CCEI_PAGE_CMP1     8'h02
`define CCEI_PAGE_CMP2     8'h03
// ==========================================================
// Control register fields
`define CCEI_CTRL_ON       7
`define CCEI_CTRL_RESULT   6
`define CCEI_CTRL_RISE     5
`define CCEI_CTRL_FALL     4
`define CCEI_CTRL_HYP_HI   3
`define CCEI_CTRL_HYP_LO   2
`define CCEI_CTRL_HYN_HI   1
`define CCEI_CTRL_HYN_LO   0
// ==========================================================
// Mode register fields
`define CCEI_MODE_RIE      5
`define CCEI_MODE_FIE      4
`define CCEI_MODE_RT_HI    1
`define CCEI_MODE_RT_LO    0
// ==========================================================
// Reset values
`define CCEI_CTRL_RST      8'h00
`define CCEI_MODE_RST      8'h02
`define CCEI_HYST_RST      2'h0
`define CCEI_RT_RST        2'h2
`endif

// ### hdl/ccei_top.v
// Control, status, edge flags and interrupt requests for three comparators.
// Assumes an 8-bit paged register port in the system clock domain and
// comparator outputs already synchronous to clk_sys.
// Functional notes
// - Enable bit 7 written one turns comparator on, zero turns it off.
// - Bit 6 shows the current comparator output, read without side effects.
// - A falling output edge sets the falling flag, bit 4.
// - A rising output edge sets the rising flag, bit 5.
// - Edge flags are sticky; only reset or software writing zero clears them.
// - Interrupts come from rising, falling or both edges per mode enables.
// - Requests reach the processor only if the extended enable is set.
// - Control bits 3 to 0 hold positive and negative hysteresis fields.
// - Negative field bits 1-0: off, 5, 10, 20 mV; code 11 largest.
// - Positive field bits 3-2 selects alike and drives the analog core.
// - A disabled comparator drives its pin output low.
// - Rising interrupt enable lives in mode register bit 5.
`include "ccei_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module ccei_top
(
    // Clock and reset
    input  wire       clk_sys,
    input  wire       rst_n,
    // Register port
    input  wire [7:0] reg_page,
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    // Extended interrupt enables, one per comparator
    input  wire [2:0] extended_irq_enable_one,
    // Analog core
    input  wire [2:0] comparator_raw,
    output reg  [2:0] comparator_on,
    output reg  [5:0] positive_hyst_sel,
    output reg  [5:0] negative_hyst_sel,
    output reg  [5:0] response_sel,
    // Pin output and interrupt requests
    output reg  [2:0] comparator_pin,
    output reg  [2:0] comparator_irq
);

    // ==========================================================
    // Per comparator state
    reg  [2:0] rise_edge_flag;
    reg  [2:0] fall_edge_flag;
    reg  [2:0] rise_irq_enable;
    reg  [2:0] fall_irq_enable;
    reg  [2:0] comparator_result;
    reg  [2:0] result_prev;
    reg  [2:0] ctrl_hit;
    reg  [2:0] mode_hit;
    reg  [2:0] rise_pulse;
    reg  [2:0] fall_pulse;
    reg  [7:0] next_rdata;
    reg  [7:0] page_id;
    integer    i;
    integer    k;

    // Page decode and edge pulses
    always @*
    begin
        next_rdata = 8'h00;
        page_id    = 8'h00;
        ctrl_hit   = 3'h0;
        mode_hit   = 3'h0;
        rise_pulse = 3'h0;
        fall_pulse = 3'h0;
        // Own loop index, so the clocked process does not share a variable
        for (k = 0; k < 3; k = k + 1)
        begin
            page_id = (k == 0) ? `CCEI_PAGE_CMP0 : ((k == 1) ? `CCEI_PAGE_CMP1 : `CCEI_PAGE_CMP2);
            ctrl_hit[k] = (reg_page == page_id) && (reg_addr == `CCEI_CTRL_ADDR);
            mode_hit[k] = (reg_page == page_id) && (reg_addr == `CCEI_MODE_ADDR);
            rise_pulse[k] = comparator_result[k] & ~result_prev[k];
            fall_pulse[k] = ~comparator_result[k] & result_prev[k];
            if (ctrl_hit[k])
            begin
                next_rdata = {comparator_on[k], comparator_result[k],
                              rise_edge_flag[k], fall_edge_flag[k],
                              positive_hyst_sel[2*k+1], positive_hyst_sel[2*k],
                              negative_hyst_sel[2*k+1], negative_hyst_sel[2*k]};
            end
            if (mode_hit[k])
            begin
                next_rdata = {2'h0, rise_irq_enable[k], fall_irq_enable[k],
                              2'h0, response_sel[2*k+1], response_sel[2*k]};
            end
        end
    end

    // Registers, flags and outputs; set of a flag wins over a clear in the same cycle
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            comparator_on     <= 3'h0;
            positive_hyst_sel <= 6'h00;
            negative_hyst_sel <= 6'h00;
            response_sel      <= {`CCEI_RT_RST, `CCEI_RT_RST, `CCEI_RT_RST};
            rise_irq_enable   <= 3'h0;
            fall_irq_enable   <= 3'h0;
            rise_edge_flag    <= 3'h0;
            fall_edge_flag    <= 3'h0;
            comparator_result <= 3'h0;
            result_prev       <= 3'h0;
            comparator_pin    <= 3'h0;
            comparator_irq    <= 3'h0;
            reg_rdata         <= 8'h00;
        end
        else
        begin
            // A disabled core reads as low so enabling can show a rising edge
            comparator_result <= comparator_raw & comparator_on;
            result_prev       <= comparator_result;
            comparator_pin    <= comparator_raw & comparator_on;
            reg_rdata         <= reg_rd ? next_rdata : reg_rdata;
            for (i = 0; i < 3; i = i + 1)
            begin
                if (reg_wr && ctrl_hit[i])
                begin
                    comparator_on[i]          <= reg_wdata[`CCEI_CTRL_ON];
                    positive_hyst_sel[2*i+1]  <= reg_wdata[`CCEI_CTRL_HYP_HI];
                    positive_hyst_sel[2*i]    <= reg_wdata[`CCEI_CTRL_HYP_LO];
                    negative_hyst_sel[2*i+1]  <= reg_wdata[`CCEI_CTRL_HYN_HI];
                    negative_hyst_sel[2*i]    <= reg_wdata[`CCEI_CTRL_HYN_LO];
                end
                if (reg_wr && mode_hit[i])
                begin
                    rise_irq_enable[i]   <= reg_wdata[`CCEI_MODE_RIE];
                    fall_irq_enable[i]   <= reg_wdata[`CCEI_MODE_FIE];
                    response_sel[2*i+1]  <= reg_wdata[`CCEI_MODE_RT_HI];
                    response_sel[2*i]    <= reg_wdata[`CCEI_MODE_RT_LO];
                end
                // Software may write either value; hardware only ever sets
                if (rise_pulse[i])
                    rise_edge_flag[i] <= 1'b1;
                else if (reg_wr && ctrl_hit[i])
                    rise_edge_flag[i] <= reg_wdata[`CCEI_CTRL_RISE];
                if (fall_pulse[i])
                    fall_edge_flag[i] <= 1'b1;
                else if (reg_wr && ctrl_hit[i])
                    fall_edge_flag[i] <= reg_wdata[`CCEI_CTRL_FALL];
                // Level request held while any enabled flag stays set and the extended enable is one
                comparator_irq[i] <= extended_irq_enable_one[i] &&
                    ((rise_edge_flag[i] && rise_irq_enable[i]) ||
                     (fall_edge_flag[i] && fall_irq_enable[i]));
            end
        end
    end

endmodule

`default_nettype wire

// ### verif/ccei_checker.sv
// Port checker for the comparator control block.
// Assumes binding onto ccei_top, all ports in the clk_sys domain.
`timescale 1ns/1ns
`default_nettype none
// ==========
// Checker
module ccei_checker
(
    // Watched ports
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic [7:0] reg_page,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [2:0] extended_irq_enable_one,
    input wire logic [2:0] comparator_on,
    input wire logic [5:0] positive_hyst_sel,
    input wire logic [5:0] negative_hyst_sel,
    input wire logic [2:0] comparator_pin,
    input wire logic [2:0] comparator_irq
);
    // Settings that only a write may move
    wire logic [14:0] cfg = {comparator_on, positive_hyst_sel, negative_hyst_sel};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    cfg_write_a: assert property (reg_wr && reg_page == 8'h01 && reg_addr == 8'h88 |=>
        {positive_hyst_sel[1:0], negative_hyst_sel[1:0]} == $past(reg_wdata[3:0])) else $error("hyst not written");
    on_write_a: assert property (reg_wr && reg_page == 8'h03 && reg_addr == 8'h88 |=>
        comparator_on[2] == $past(reg_wdata[7])) else $error("enable not written");
    bad_page_a: assert property (reg_wr && reg_page == 8'h00 |=> $stable(cfg)) else $error("stray write");
    // Reset in the previous cycle may legally move the settings
    cfg_hold_a: assert property ($past(rst_n) && !$past(reg_wr) |-> $stable(cfg)) else $error("cfg moved");
    rdata_hold_a: assert property ($past(rst_n) && !$past(reg_rd) |-> $stable(reg_rdata))
        else $error("rdata moved");
    irq_ext_a: assert property (comparator_irq[0] |-> $past(extended_irq_enable_one[0]))
        else $error("irq without enable");
    pin_off_a: assert property (!comparator_on[0] [*2] |-> !comparator_pin[0]) else $error("pin high");
    unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h90 |=> reg_rdata == 8'h00)
        else $error("unmapped read nonzero");
endmodule
bind ccei_top ccei_checker u_ccei_checker (.clk_sys, .rst_n, .reg_page, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .extended_irq_enable_one, .comparator_on, .positive_hyst_sel, .negative_hyst_sel,
    .comparator_pin, .comparator_irq);
`default_nettype wire

// ### verif/ccei_analog_model.sv
// Behavioural comparator core.
// Assumes the bench sets the input level; output is synchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
// ==========
// Core model
module ccei_analog_model
(
    // Clock, control and level
    input  wire logic       clk_sys,
    input  wire logic [2:0] comparator_on,
    input  wire logic [2:0] level,
    output var  logic [2:0] comparator_raw
);
    // A shut-down core reads low, so a stale level never leaks out
    always @(posedge clk_sys)
    begin
        comparator_raw <= level & comparator_on;
    end
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the comparator control block.
// Assumes ccei_top, the core model and the bound checker are compiled.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin num_checks++; \
    if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end
// ==========
// Bench top
module tb;
    logic       clk_sys = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [7:0] reg_page = 8'h00, reg_addr = 8'h00, reg_wdata = 8'h00;
    logic [2:0] ext = 3'h1, level = 3'h0;
    wire  [7:0] reg_rdata;
    wire  [2:0] raw, on, pin, irq;
    wire  [5:0] hyp, hyn, rsel;
    int         mismatches = 0, num_checks = 0, cycles = 0, i;
    ccei_top u_ccei_top (.clk_sys, .rst_n, .reg_page, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .extended_irq_enable_one(ext), .comparator_raw(raw), .comparator_on(on), .positive_hyst_sel(hyp),
        .negative_hyst_sel(hyn), .response_sel(rsel), .comparator_pin(pin), .comparator_irq(irq));
    ccei_analog_model u_ccei_analog_model (.clk_sys, .comparator_on(on), .level, .comparator_raw(raw));
    initial forever #50 clk_sys = ~clk_sys;
    // Hang guard: the whole run needs well under this
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            mismatches++;
            finish_test();
        end
    end
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] p, a, d);
        @(posedge clk_sys) #1;
        {reg_page, reg_addr, reg_wdata, reg_wr} = {p, a, d, 1'h1};
        @(posedge clk_sys) #1;
        reg_wr = 1'h0;
    endtask
    task automatic rd(input logic [7:0] p, a, e);
        @(posedge clk_sys) #1;
        {reg_page, reg_addr, reg_rd} = {p, a, 1'h1};
        @(posedge clk_sys) #1;
        reg_rd = 1'h0;
        idle(1);
        `CHK("rdata", e, reg_rdata)
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        idle(2);
        rst_n = 1'h1;
        for (i = 1; i < 4; i++)
        begin
            rd(i[7:0], 8'h88, 8'h00);
            rd(i[7:0], 8'h89, 8'h02);
        end
        `CHK("rsel rst", 6'h2A, rsel)
        wr(8'h01, 8'h88, 8'hCF); // Result bit is read-only
        `CHK("on", 3'h1, on)
        idle(2); // Let the core settle before trusting its output
        rd(8'h01, 8'h88, 8'h8F);
        `CHK("hyst", 4'hF, {hyp[1:0], hyn[1:0]})
        wr(8'h01, 8'h89, 8'h30);
        `CHK("rsel wr", 6'h28, rsel)
        level = 3'h1;
        idle(4);
        `CHK("irq rise", 3'h1, irq)
        rd(8'h01, 8'h88, 8'hEF);
        `CHK("pin", 3'h1, pin)
        ext = 3'h0;
        idle(2);
        `CHK("irq gated", 3'h0, irq)
        ext = 3'h1;
        wr(8'h01, 8'h88, 8'h8F);
        rd(8'h01, 8'h88, 8'hCF);
        `CHK("irq clear", 3'h0, irq)
        level = 3'h0;
        idle(4);
        rd(8'h01, 8'h88, 8'h9F);
        `CHK("irq fall", 3'h1, irq)
        wr(8'h01, 8'h89, 8'h20);
        idle(2);
        `CHK("irq masked", 3'h0, irq)
        for (i = 0; i < 4; i++)
            wr(i[7:0], 8'h88, 8'h00);
        level = 3'h7;
        idle(3);
        `CHK("pin off", 3'h0, pin)
        rd(8'h01, 8'h88, 8'h00);
        rd(8'h01, 8'h90, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
